// >>> core/hpr_receiver.sv
// Host parallel byte receiver with 512-byte FIFO, direct latch and APB slave.
//
// Overview of operation
// - Buffered mode: capture data lines into FIFO right after strobe falls.
// - Busy rises in the same cycle the byte is captured.
// - Buffered mode: hardware pulses acknowledge, then drops busy, with no CPU action unless the FIFO is full.
// - Empty flag clears readable by CPU when a byte enters the FIFO.
// - CPU reads FIFO bytes in arrival order; each read pops one byte.
// - FIFO holds up to 512 unread bytes.
// - At 512 bytes a full flag sets and drives the interrupt request.
// - Direct mode: bypass FIFO, latch data into holding register, raise busy.
// - Direct mode: interrupt rises in the same cycle the byte is latched.
// - Direct mode: busy released and acknowledge sent for every byte.
// - Direct mode: release and acknowledge are triggered by the processor.
// - Buffered mode is selected after reset.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps

module hpr_receiver #(
	parameter int DEPTH     = hpr_pkg::FIFO_DEPTH,
	parameter int LEAD_CYC  = hpr_pkg::BUSY_LEAD_CYC,
	parameter int ACK_CYC   = hpr_pkg::ACK_WIDTH_CYC
) (
	input  wire logic        mclk_in,
	input  wire logic        reset_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic [7:0]  host_data_in,
	input  wire logic        host_strobe_n_in,
	output logic             host_busy_out,
	output logic             host_ack_n_out,
	output logic             cpu_irq_out
);

	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------
	logic [7:0]        mem_r [DEPTH];
	logic [AW-1:0]     wr_ptr_r;
	logic [AW-1:0]     rd_ptr_r;
	logic [AW:0]       count_r;
	logic [7:0]        latch_r;
	logic              latched_r;
	logic              direct_r;
	logic              irq_en_r;
	logic              strobe_d_r;
	logic              busy_r;
	logic              ack_n_r;
	logic [15:0]       timer_r;
	logic              release_req_r;
	logic [31:0]       prdata_r;
	logic              rd_wait_r;
	hpr_pkg::hpr_state_e state_r;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire       apb_acc   = psel_in & penable_in;
	wire       apb_wr    = apb_acc & pwrite_in;
	wire       apb_rd    = apb_acc & ~pwrite_in;
	wire       sel_ctrl  = paddr_in == hpr_pkg::ADDR_CTRL;
	wire       sel_stat  = paddr_in == hpr_pkg::ADDR_STATUS;
	wire       sel_data  = paddr_in == hpr_pkg::ADDR_DATA;
	wire       sel_level = paddr_in == hpr_pkg::ADDR_LEVEL;
	wire       sel_hsk   = paddr_in == hpr_pkg::ADDR_HSK;
	wire       mapped    = sel_ctrl | sel_stat | sel_data | sel_level
	                       | sel_hsk;
	wire       fifo_empty = count_r == '0;
	wire       fifo_full  = count_r == (AW+1)'(DEPTH);
	wire       strobe_fall = strobe_d_r & ~host_strobe_n_in;
	// Strobes arriving while busy are ignored; the host must not send them.
	wire       take      = strobe_fall & ~busy_r;
	wire       push      = take & ~direct_r;
	wire       grab      = take & direct_r;
	// Reads take one wait state so that the registered data already
	// stands at the edge where ready is seen high.
	wire       rd_first  = apb_rd & ~rd_wait_r;
	wire       rd_last   = apb_rd & rd_wait_r;
	wire       pop       = rd_last & sel_data & ~direct_r & ~fifo_empty;
	wire       rel_write = apb_wr & sel_hsk
	                       & pwdata_in[hpr_pkg::HSK_RELEASE_BIT];
	wire       timer_done = timer_r == '0;

	wire [31:0] stat_word = {28'h0000000, busy_r, latched_r, fifo_full,
	                         fifo_empty};
	wire [31:0] rd_mux =
		sel_ctrl  ? {30'h00000000, irq_en_r, direct_r} :
		sel_stat  ? stat_word :
		sel_data  ? (direct_r ? {24'h000000, latch_r}
		                      : {24'h000000, mem_r[rd_ptr_r]}) :
		sel_level ? {{(31-AW){1'b0}}, count_r} :
		32'h00000000;

	assign pready_out  = ~apb_rd | rd_wait_r;
	assign pslverr_out = apb_acc & ~mapped;
	assign prdata_out  = prdata_r;
	assign host_busy_out  = busy_r;
	assign host_ack_n_out = ack_n_r;
	// Full in buffered mode, a waiting byte in direct mode.
	assign cpu_irq_out = irq_en_r & ((fifo_full & ~direct_r)
	                                 | (latched_r & direct_r));

	// ----------------------------------------------------------------
	// FIFO
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (push)
			mem_r[wr_ptr_r] <= host_data_in;
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push & ~pop)
				count_r <= count_r + 1'b1;
			else if (pop & ~push)
				count_r <= count_r - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers and APB
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			direct_r      <= hpr_pkg::CTRL_DIRECT_RST;
			irq_en_r      <= hpr_pkg::CTRL_IRQ_EN_RST;
			prdata_r      <= 32'h00000000;
			rd_wait_r     <= 1'b0;
			latch_r       <= 8'h00;
			latched_r     <= 1'b0;
			release_req_r <= 1'b0;
			strobe_d_r    <= 1'b1;
		end else begin
			strobe_d_r <= host_strobe_n_in;
			rd_wait_r  <= rd_first;
			if (rd_first)
				prdata_r <= rd_mux;
			if (apb_wr & sel_ctrl) begin
				direct_r <= pwdata_in[hpr_pkg::CTRL_DIRECT_BIT];
				irq_en_r <= pwdata_in[hpr_pkg::CTRL_IRQ_EN_BIT];
			end
			if (grab) begin
				latch_r <= host_data_in;
			end
			// A new byte wins over the clear from reading the latch.
			if (grab)
				latched_r <= 1'b1;
			else if (rd_last & sel_data & direct_r)
				latched_r <= 1'b0;
			if (rel_write & direct_r)
				release_req_r <= 1'b1;
			else if (state_r == hpr_pkg::HPR_HOLD)
				release_req_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Host handshake
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			state_r <= hpr_pkg::HPR_IDLE;
			busy_r  <= 1'b0;
			ack_n_r <= 1'b1;
			timer_r <= '0;
		end else begin
			case (state_r)
				hpr_pkg::HPR_IDLE: begin
					if (take) begin
						busy_r  <= 1'b1;
						timer_r <= 16'(LEAD_CYC);
						state_r <= direct_r ? hpr_pkg::HPR_HOLD
						                    : hpr_pkg::HPR_WAIT;
					end
				end
				hpr_pkg::HPR_WAIT: begin
					// Holding busy while full keeps the host from overrunning.
					if (timer_done & ~fifo_full) begin
						ack_n_r <= 1'b0;
						timer_r <= 16'(ACK_CYC);
						state_r <= hpr_pkg::HPR_ACK;
					end else if (!timer_done) begin
						timer_r <= timer_r - 16'h0001;
					end
				end
				hpr_pkg::HPR_HOLD: begin
					if (release_req_r) begin
						ack_n_r <= 1'b0;
						timer_r <= 16'(ACK_CYC);
						state_r <= hpr_pkg::HPR_ACK;
					end
				end
				hpr_pkg::HPR_ACK: begin
					if (timer_done) begin
						ack_n_r <= 1'b1;
						busy_r  <= 1'b0;
						state_r <= hpr_pkg::HPR_IDLE;
					end else begin
						timer_r <= timer_r - 16'h0001;
					end
				end
				default: begin
					state_r <= hpr_pkg::HPR_IDLE;
					busy_r  <= 1'b0;
					ack_n_r <= 1'b1;
				end
			endcase
		end
	end

endmodule

// >>> core/hpr_pkg.sv
// Package with register map, field positions and timing for the host parallel receiver.
package hpr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_DATA   = 12'h008;
	localparam logic [11:0] ADDR_LEVEL  = 12'h00C;
	localparam logic [11:0] ADDR_HSK    = 12'h010;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_DIRECT_BIT   = 0;
	localparam int CTRL_IRQ_EN_BIT   = 1;
	localparam int STAT_EMPTY_BIT    = 0;
	localparam int STAT_FULL_BIT     = 1;
	localparam int STAT_LATCHED_BIT  = 2;
	localparam int STAT_BUSY_BIT     = 3;
	localparam int HSK_RELEASE_BIT   = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic CTRL_DIRECT_RST = 1'b0;
	localparam logic CTRL_IRQ_EN_RST = 1'b1;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int BUSY_LEAD_NS  = 1000;
	localparam int ACK_WIDTH_NS  = 1000;
	localparam int BUSY_LEAD_CYC = (BUSY_LEAD_NS * 1000) / CLK_PERIOD_PS;
	localparam int ACK_WIDTH_CYC = (ACK_WIDTH_NS * 1000) / CLK_PERIOD_PS;

	localparam int FIFO_DEPTH = 512;

	typedef enum logic [3:0] {
		HPR_IDLE = 4'h1,
		HPR_WAIT = 4'h2,
		HPR_ACK  = 4'h4,
		HPR_HOLD = 4'h8
	} hpr_state_e;

endpackage

// >>> tb/hpr_receiver_chk.sv
// Checker of the host handshake of the receiver.
`timescale 1ns/100ps
module hpr_chk #(parameter int DEPTH = 512, LEAD_CYC = 2, ACK_CYC = 2) (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic host_strobe_n_in,
	input wire logic host_busy_out,
	input wire logic host_ack_n_out,
	input wire logic cpu_irq_out
);
	logic dir_r;
	wire  wr = psel_in & penable_in & pwrite_in;
	wire  hsk = wr & (paddr_in == hpr_pkg::ADDR_HSK);
	// The mode bit is mirrored here because only the bus shows it.
	always_ff @(posedge mclk_in) begin
		if (reset_in)
			dir_r <= 1'b0;
		else if (wr & (paddr_in == hpr_pkg::ADDR_CTRL))
			dir_r <= pwdata_in[hpr_pkg::CTRL_DIRECT_BIT];
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	chk_busy_strobe: assert property (
		$fell(host_strobe_n_in) && !host_busy_out |=> host_busy_out)
		else $error("busy late");
	chk_ack_busy: assert property (
		!host_ack_n_out |-> host_busy_out) else $error("ack idle");
	chk_ack_width: assert property (
		$fell(host_ack_n_out) |-> !host_ack_n_out[*3] ##1 host_ack_n_out)
		else $error("ack width");
	chk_release_pair: assert property (
		$fell(host_busy_out) |-> $rose(host_ack_n_out)) else $error("release");
	chk_auto_ack: assert property (
		!dir_r && $rose(host_busy_out) ##1 !cpu_irq_out
		|-> ##[1:3] $fell(host_ack_n_out)) else $error("no auto ack");
	chk_direct_irq: assert property (
		dir_r && $fell(host_strobe_n_in) && !host_busy_out |=> cpu_irq_out)
		else $error("direct irq");
	chk_cpu_ack: assert property (
		dir_r && $fell(host_ack_n_out)
		|-> $past(hsk) || $past(hsk, 2) || $past(hsk, 3)) else $error("ack");
	chk_full_busy: assert property (
		!dir_r && cpu_irq_out && host_busy_out |=> host_busy_out)
		else $error("full busy");
	cover property (!dir_r && $fell(host_ack_n_out));
	cover property (!dir_r && $rose(cpu_irq_out));
	cover property (dir_r && hsk);
endmodule

// >>> tb/hpr_host_model.sv
// Host computer model that strobes bytes into the receiver.
`timescale 1ns/100ps
module hpr_host_model (
	input  wire logic       mclk_in,
	input  wire logic       host_busy_in,
	output logic      [7:0] host_data_out,
	output logic            host_strobe_n_out
);
	initial begin
		host_data_out = 8'h00;
		host_strobe_n_out = 1'b1;
	end
	task automatic send(input logic [7:0] b, input int gap);
		do @(posedge mclk_in); while (host_busy_in);
		repeat (gap) @(posedge mclk_in);
		host_data_out <= b;
		@(posedge mclk_in);
		host_strobe_n_out <= 1'b0;
		@(posedge mclk_in);
		host_strobe_n_out <= 1'b1;
		// Hold time is over, so the lines stop showing the byte.
		host_data_out <= ~b;
	endtask
endmodule

// >>> tb/test_host_parallel_byte_receiver.sv
// Self-checking bench of the host parallel byte receiver.
`timescale 1ns/100ps
module test_host_parallel_byte_receiver;
	typedef struct {logic [11:0] a; logic [31:0] d; logic er;} hpr_row_s;
	logic mclk_in = 1'b0, reset_in = 1'b1, e;
	logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, prdata_out, q;
	logic [7:0] host_data_in;
	logic pready_out, pslverr_out, host_strobe_n_in;
	logic host_busy_out, host_ack_n_out, cpu_irq_out;
	int fails = 0, n_checks = 0, cyc = 0, i;
	hpr_row_s rows [5] = '{'{12'h000, 32'h2, 1'b0},
		'{12'h004, 32'h1, 1'b0}, '{12'h00C, 32'h0, 1'b0},
		'{12'h014, 32'h0, 1'b1}, '{12'hFFC, 32'h0, 1'b1}};
	hpr_receiver #(.LEAD_CYC(2), .ACK_CYC(2)) dut (.*);
	hpr_host_model host (.mclk_in(mclk_in), .host_busy_in(host_busy_out),
		.host_data_out(host_data_in), .host_strobe_n_out(host_strobe_n_in));
	// ------------------------------------------------------------
	// Bus and report tasks
	// ------------------------------------------------------------
	task automatic check(input string n, input logic [31:0] s, x);
		n_checks++;
		if (s !== x) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", n, x, s);
		end
	endtask
	// Read data and error are taken at the edge where ready is high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge mclk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		do @(posedge mclk_in); while (pready_out !== 1'b1);
		e = pslverr_out;
		q = prdata_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always #4 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge mclk_in);
		reset_in <= 1'b0;
		foreach (rows[k]) begin
			apb(1'b0, rows[k].a, 32'h0);
			check("reg", q, rows[k].d);
			check("err", 32'(e), 32'(rows[k].er));
		end
		$display("test registers done");
		host.send(8'hA5, 0);
		host.send(8'h5A, 3);
		apb(1'b0, 12'h004, 32'h0);
		check("empty", q & 32'h1, 32'h0);
		apb(1'b0, 12'h008, 32'h0);
		check("byte", q & 32'hFF, 32'hA5);
		apb(1'b0, 12'h008, 32'h0);
		check("byte", q & 32'hFF, 32'h5A);
		$display("test buffered done");
		for (i = 0; i < 512; i++)
			host.send(i[7:0], 0);
		repeat (20) @(posedge mclk_in);
		check("full", 32'({cpu_irq_out, host_busy_out}), 32'h3);
		apb(1'b0, 12'h00C, 32'h0);
		check("level", q, 32'h200);
		for (i = 0; i < 512; i++) begin
			apb(1'b0, 12'h008, 32'h0);
			check("fifo", q & 32'hFF, 32'(i[7:0]));
		end
		apb(1'b0, 12'h004, 32'h0);
		check("drained", q & 32'hB, 32'h1);
		$display("test full done");
		apb(1'b1, 12'h000, 32'h3);
		for (i = 0; i < 2; i++) begin
			host.send(8'h3C ^ i[7:0], 0);
			repeat (20) @(posedge mclk_in);
			check("pins", 32'({cpu_irq_out, host_busy_out, host_ack_n_out}),
				32'h7);
			apb(1'b0, 12'h00C, 32'h0);
			check("bypass", q, 32'h0);
			apb(1'b0, 12'h008, 32'h0);
			check("latch", q & 32'hFF, 32'h3C ^ i);
			apb(1'b1, 12'h010, 32'h1);
		end
		$display("test direct done");
		reset_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		reset_in <= 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		check("mode", q, 32'h2);
		$display("test reset done");
		print_verdict();
	end
endmodule
bind hpr_receiver hpr_chk #(.DEPTH(DEPTH), .LEAD_CYC(LEAD_CYC),
	.ACK_CYC(ACK_CYC)) chk (.*);
